// File: logic/current_dac_update_scheduler.sv
// register file and update scheduling for the current-output converter
// assumes AXI4-Lite master on clk_sys; timer pulses are one cycle, same clock
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`default_nettype none
module current_dac_update_scheduler
#(
  parameter int data_width = 10
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // update events
  input wire logic [3:0] timer_overflow,
  input wire logic external_start_pin,
  // port pin control
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic gpio_pullup,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_pullup,
  output logic pin_analog_route,
  // analog converter control
  output logic bias_enable,
  output logic [1:0] full_scale_select,
  output logic [data_width-1:0] converter_latch
);
  // elaboration check: the latch, readback and byte split are built for ten bits only
  if (data_width != 10)
  begin
    $error("data_width must be 10");
  end

  logic converter_enable_bit_q;
  logic [2:0] update_source_select_q;
  logic [1:0] full_scale_select_q;
  logic [7:0] data_high_byte_q;
  logic [1:0] data_low_byte_q;
  logic [9:0] latch_q;
  logic aw_held_q;
  logic [7:0] aw_addr_q;
  logic w_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic start_rise;
  logic start_fall;

  ////////////////////////////////////////////////////////////////////////////
  // external start pin edges
  edge_sync u_start
  (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin(external_start_pin),
    .rise(start_rise),
    .fall(start_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write channel decode; address and data are captured in either order
  wire aw_take = s_axi_awvalid & ~aw_held_q & ~bvalid_q;
  wire w_take = s_axi_wvalid & ~w_held_q & ~bvalid_q;
  wire [7:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
  wire wr_go = (aw_held_q | aw_take) & (w_held_q | w_take);
  wire wr_lane0 = wr_go & wr_strb[0];
  wire wr_ctrl = wr_lane0 & (wr_addr == idac_pkg::ctrl_off);
  wire wr_low = wr_lane0 & (wr_addr == idac_pkg::data_low_off);
  wire wr_high = wr_lane0 & (wr_addr == idac_pkg::data_high_off);
  wire wr_known = (wr_addr == idac_pkg::ctrl_off) | (wr_addr == idac_pkg::data_low_off)
    | (wr_addr == idac_pkg::data_high_off) | (wr_addr == idac_pkg::latch_off);
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // update event select; a stale source reprogram cannot fire early
  wire [2:0] src = update_source_select_q;
  wire update_event =
    (src == idac_pkg::src_timer0) ? timer_overflow[0] :
    (src == idac_pkg::src_timer1) ? timer_overflow[1] :
    (src == idac_pkg::src_timer2) ? timer_overflow[2] :
    (src == idac_pkg::src_timer3) ? timer_overflow[3] :
    (src == idac_pkg::src_rise) ? start_rise :
    (src == idac_pkg::src_fall) ? start_fall :
    (src == idac_pkg::src_any) ? (start_rise | start_fall) :
    wr_high;
  // the high byte being written this cycle goes straight to the latch
  wire [7:0] next_high = wr_high ? wr_data[7:0] : data_high_byte_q;
  wire [1:0] next_low = wr_low ? wr_data[7:6] : data_low_byte_q;
  wire [9:0] latch_d = {next_high, next_low};

  ////////////////////////////////////////////////////////////////////////////
  // control and data holding registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      converter_enable_bit_q <= idac_pkg::ctrl_reset[idac_pkg::enable_pos];
      update_source_select_q <= idac_pkg::ctrl_reset[idac_pkg::src_lsb +: 3];
      full_scale_select_q <= idac_pkg::ctrl_reset[idac_pkg::range_lsb +: 2];
      data_high_byte_q <= idac_pkg::data_reset;
      data_low_byte_q <= idac_pkg::data_reset[7:6];
    end
    else
    begin
      if (wr_ctrl)
      begin
        converter_enable_bit_q <= wr_data[idac_pkg::enable_pos];
        update_source_select_q <= wr_data[idac_pkg::src_lsb +: 3];
        full_scale_select_q <= wr_data[idac_pkg::range_lsb +: 2];
      end
      data_high_byte_q <= next_high;
      data_low_byte_q <= next_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter input latch: all ten bits in one edge
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      latch_q <= 10'h000;
    else if (update_event)
      latch_q <= latch_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // write handshake state
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= idac_pkg::resp_okay;
    end
    else
    begin
      if (wr_go)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? idac_pkg::resp_okay : idac_pkg::resp_slverr;
      end
      else
      begin
        if (aw_take)
        begin
          aw_held_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (w_take)
        begin
          w_held_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready)
          bvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode; unused bits read zero
  wire [31:0] ctrl_word = {24'h000000, converter_enable_bit_q, update_source_select_q,
    2'b00, full_scale_select_q};
  wire [31:0] rd_word =
    (s_axi_araddr == idac_pkg::ctrl_off) ? ctrl_word :
    (s_axi_araddr == idac_pkg::data_low_off) ? {24'h000000, data_low_byte_q, 6'h00} :
    (s_axi_araddr == idac_pkg::data_high_off) ? {24'h000000, data_high_byte_q} :
    (s_axi_araddr == idac_pkg::latch_off) ? {22'h0, latch_q} : 32'h0000_0000;
  wire rd_known = (s_axi_araddr == idac_pkg::ctrl_off)
    | (s_axi_araddr == idac_pkg::data_low_off)
    | (s_axi_araddr == idac_pkg::data_high_off) | (s_axi_araddr == idac_pkg::latch_off);
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // read answer register; data and response stand until rready is seen
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= idac_pkg::resp_okay;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_known ? idac_pkg::resp_okay : idac_pkg::resp_slverr;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin handover and analog control; pin stays digital while disabled
  assign pin_out = converter_enable_bit_q ? 1'b0 : gpio_out;
  assign pin_oe = converter_enable_bit_q ? 1'b0 : gpio_oe;
  assign pin_pullup = converter_enable_bit_q ? 1'b0 : gpio_pullup;
  assign pin_analog_route = converter_enable_bit_q;
  assign bias_enable = converter_enable_bit_q;
  assign full_scale_select = full_scale_select_q;
  assign converter_latch = latch_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  pin_release_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    converter_enable_bit_q |-> (!pin_oe && !pin_pullup && pin_analog_route))
    else $error("pin not released while enabled");
  pin_gpio_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !converter_enable_bit_q |-> (pin_oe == gpio_oe && !pin_analog_route))
    else $error("pin not under port control while disabled");
  bias_follow_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_ctrl |=> (bias_enable == $past(wr_data[idac_pkg::enable_pos])))
    else $error("bias does not follow enable");
  high_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (src == idac_pkg::src_high_write && wr_high) |=> latch_q == $past(latch_d))
    else $error("high byte write did not update latch");
  low_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (src == idac_pkg::src_high_write && !wr_high) |=> $stable(latch_q))
    else $error("latch changed without high byte write");
  timer_update_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (src == idac_pkg::src_timer2 && timer_overflow[2])
    |=> latch_q == {$past(next_high), $past(next_low)})
    else $error("timer 2 overflow did not update latch");
  timer_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (src[2] == 1'b0 && !timer_overflow[src[1:0]]) |=> $stable(latch_q))
    else $error("latch changed without timer overflow");
  edge_update_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (src == idac_pkg::src_fall && !start_fall) |=> $stable(latch_q))
    else $error("latch changed without falling start edge");
  range_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !wr_ctrl |=> $stable(full_scale_select))
    else $error("range changed without control write");
  justify_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_low |=> data_low_byte_q == $past(wr_data[7:6]))
    else $error("low byte bits 7:6 not held");
endmodule
`default_nettype wire

// File: logic/idac_pkg.sv
// constants for the current-output converter update scheduler
// assumes a single 10 MHz system clock and an AXI4-Lite register bus
`default_nettype none
package idac_pkg;
  // byte addresses of the registers
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] data_low_off = 8'h04;
  localparam logic [7:0] data_high_off = 8'h08;
  localparam logic [7:0] latch_off = 8'h0c;
  // control register field positions
  localparam int enable_pos = 7;
  localparam int src_lsb = 4;
  localparam int range_lsb = 0;
  // reset values
  localparam logic [7:0] ctrl_reset = 8'h72;
  localparam logic [7:0] data_reset = 8'h00;
  // bus answers
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  // update source codes
  typedef enum logic [2:0] {
    src_timer0 = 3'b000,
    src_timer1 = 3'b001,
    src_timer2 = 3'b010,
    src_timer3 = 3'b011,
    src_rise = 3'b100,
    src_fall = 3'b101,
    src_any = 3'b110,
    src_high_write = 3'b111
  } update_source_e;
endpackage
`default_nettype wire

// File: logic/edge_sync.sv
// two-flop synchroniser with edge detection for the external start pin
// assumes the pin is asynchronous to clk_sys
`default_nettype none
module edge_sync
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // pin and edges
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  ////////////////////////////////////////////////////////////////////////////
  // meta_q is read only by sync_q; edge decode reads sync_q and last_q, avoiding metastable decode
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule
`default_nettype wire

// File: sim/current_dac_update_scheduler_tb.sv
// self-checking bench for the converter update scheduler
// assumes the scheduler, its package and edge_sync are compiled first
`default_nettype none
module current_dac_update_scheduler_tb;
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
  logic [3:0] tov = 4'h0;
  logic xpin = 1'h0, go = 1'h0, goe = 1'h0, gpu = 1'h0;
  wire logic awr, wr, bv, arr, rv, po, poe, ppu, route, bias;
  wire logic [1:0] br, rr, fs;
  wire logic [31:0] rd;
  wire logic [9:0] latch;
  logic [31:0] rdat;
  logic [1:0] rrsp;
  logic [1:0] wrsp;
  logic [3:0] ws = 4'h1;
  logic [9:0] lx;
  int n_errors = 0;
  int compares = 0;
  current_dac_update_scheduler u_current_dac_update_scheduler (
    .clk_sys(clk_sys), .arst_n(arst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .timer_overflow(tov),
    .external_start_pin(xpin), .gpio_out(go), .gpio_oe(goe), .gpio_pullup(gpu),
    .pin_out(po), .pin_oe(poe), .pin_pullup(ppu), .pin_analog_route(route),
    .bias_enable(bias), .full_scale_select(fs), .converter_latch(latch));
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  // compare and closing
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic summarize();
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // bus tasks: handshakes judged at the falling edge, where values are settled
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    tb = 1'h0;
    n = 0;
    @(posedge clk_sys);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bre <= 1'h1;
    while (!tb && n < 50)
    begin
      @(negedge clk_sys);
      ta = awv && awr;
      tw = wv && wr;
      tb = (bv === 1'h1);
      wrsp = br;
      n++;
      @(posedge clk_sys);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
      if (tb) bre <= 1'h0;
    end
    if (!tb) n_errors++;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    logic ta, tr;
    int n;
    tr = 1'h0;
    n = 0;
    @(posedge clk_sys);
    ara <= a;
    arv <= 1'h1;
    rre <= 1'h1;
    while (!tr && n < 50)
    begin
      @(negedge clk_sys);
      ta = arv && arr;
      tr = (rv === 1'h1);
      rdat = rd;
      rrsp = rr;
      n++;
      @(posedge clk_sys);
      if (ta) arv <= 1'h0;
      if (tr) rre <= 1'h0;
    end
    if (!tr) n_errors++;
  endtask
  task automatic pulse(input int k);
    @(posedge clk_sys);
    tov <= 4'h1 << k;
    @(posedge clk_sys);
    tov <= 4'h0;
    @(negedge clk_sys);
  endtask
  task automatic pin_to(input logic v);
    @(posedge clk_sys);
    xpin <= v;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_and_pin();
    rd_reg(8'h00);
    chk("ctrl reset", 32'h72, rdat);
    chk("ctrl resp", 32'h0, rrsp);
    chk("range reset", 32'h2, fs);
    chk("bias off", 32'h0, bias);
    @(posedge clk_sys);
    {go, goe, gpu} <= 3'h7;
    @(negedge clk_sys);
    chk("pin pass", 32'he, {po, poe, ppu, route});
    wr_reg(8'h00, 32'hf2);
    @(negedge clk_sys);
    chk("pin to converter", 32'h3, {po, poe, ppu, route, bias});
    @(posedge clk_sys);
    {go, goe, gpu} <= 3'h0; // port logic skips the pin while converting
    @(negedge clk_sys);
    chk("pin skipped", 32'h3, {po, poe, ppu, route, bias});
    @(posedge clk_sys);
    {go, goe, gpu} <= 3'h6;
    wr_reg(8'h00, 32'h72);
    @(negedge clk_sys);
    chk("pin back", 32'h18, {po, poe, ppu, route, bias});
  endtask
  task automatic t_ranges();
    for (int r = 0; r < 4; r++)
    begin
      wr_reg(8'h00, 32'h7c | r);
      rd_reg(8'h00);
      chk("ctrl readback", 32'h70 | r, rdat);
      chk("range out", r, fs);
    end
  endtask
  task automatic t_high_write();
    wr_reg(8'h04, 32'hff);
    rd_reg(8'h04);
    chk("low readback", 32'hc0, rdat);
    chk("low held", {22'h0, lx}, latch);
    wr_reg(8'h08, 32'ha5);
    chk("write resp", 32'h0, wrsp);
    lx = {8'ha5, 2'h3};
    chk("high update", {22'h0, lx}, latch);
    // 8-bit use: low byte set once, then only high bytes written
    wr_reg(8'h04, 32'h00);
    chk("low zero held", {22'h0, lx}, latch);
    wr_reg(8'h08, 32'h3c);
    chk("8-bit first", {22'h0, 8'h3c, 2'h0}, latch);
    wr_reg(8'h08, 32'hc3);
    lx = {8'hc3, 2'h0};
    chk("8-bit second", {22'h0, lx}, latch);
    // byte lane 0 off: the write must leave data and latch alone
    @(posedge clk_sys);
    ws <= 4'h0;
    wr_reg(8'h08, 32'h5a);
    ws <= 4'h1;
    chk("lane off latch", {22'h0, lx}, latch);
    rd_reg(8'h08);
    chk("lane off high", 32'hc3, rdat);
    wr_reg(8'h10, 32'h1);
    chk("unmapped wr resp", 32'h2, wrsp);
    rd_reg(8'h10);
    chk("unmapped resp", 32'h2, rrsp);
    chk("unmapped data", 32'h0, rdat);
  endtask
  task automatic t_timers();
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(8'h00, (k << 4) | 32'h2);
      wr_reg(8'h04, k << 6);
      wr_reg(8'h08, 32'h30 + k);
      pulse((k + 1) % 4);
      chk("other timer", {22'h0, lx}, latch);
      pulse(k);
      lx = {8'h30 + k[7:0], k[1:0]};
      chk("own timer", {22'h0, lx}, latch);
    end
  endtask
  task automatic t_pin_edges();
    for (int s = 4; s < 7; s++)
    begin
      wr_reg(8'h00, (s << 4) | 32'h2);
      wr_reg(8'h04, 32'h80);
      wr_reg(8'h08, 32'h50 + s);
      pin_to(1'h1);
      if (s != 5) lx = {8'h50 + s[7:0], 2'h2};
      chk("after rise", {22'h0, lx}, latch);
      // fresh data so a wrongly taken falling edge shows
      wr_reg(8'h08, 32'h60 + s);
      chk("held for edge", {22'h0, lx}, latch);
      pin_to(1'h0);
      if (s != 4) lx = {8'h60 + s[7:0], 2'h2};
      chk("after fall", {22'h0, lx}, latch);
      rd_reg(8'h0c);
      chk("latch readback", {22'h0, lx}, rdat);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial
  begin
    lx = 10'h0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'h1;
    t_reset_and_pin();
    t_ranges();
    t_high_write();
    t_timers();
    t_pin_edges();
    summarize();
  end
  initial
  begin
    #1000000;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
